/* logic/lfoc_top.sv */
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
// Overview of operation
// - Two modes: external clock on the input pin, or a crystal across input and output pins.
// - After power-on reset, or a system reset while unlocked, the oscillator is disabled and both pins are left to general I/O.
// - Enabled in crystal mode, the block takes over both the input and the output pin.
// - Enabled in external-clock mode, only the input pin is taken over.
// - Writing one to the enable bit starts the oscillator, writing zero stops it.
// - The crystal select bit picks crystal mode when one and external-clock mode when zero.
// - The 32.768 kHz output runs only while its output-enable bit is set.
// - A 1.024 kHz output with its own enable bit goes only to the real-time clock.
// - Setting the write lock freezes the external oscillator configuration until a power-on reset.
// - With the enable bit clear the oscillator stays stopped in every sleep mode.
// - When enabled, sleep behaviour follows run-in-standby, on-demand and enable together.
// - A status register gathers sub-unit status and those events can raise interrupts.
// - A status event wakes the system from standby only when its interrupt enable is set.
// - Software can enable and disable both the external and the low-power osc, and calibrate the low-power one.
module lfoc_top (
    // System clock and resets
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        por_rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Sleep control
    input  wire logic        standby_mode,
    input  wire logic        clk_request,
    // Link clock from pin
    input  wire logic        xtal_in_clk,
    // Pin ownership and crystal drive
    output logic             xtal_in_pin_override,
    output logic             xtal_out_pin_override,
    output logic             xtal_out_pin_drive,
    // Clock outputs and events
    output logic             clk_32k_out,
    output logic             clk_1k_rtc_out,
    output logic             ulp_osc_enable,
    output logic [lfoc_pkg::LFOC_ULP_CAL_W-1:0] ulp_osc_cal,
    output logic             irq_out,
    output logic             wake_out
);
    import lfoc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [31:0] ext_ctrl_reg;
    logic [31:0] ulp_ctrl_reg;
    logic [31:0] int_en_reg;
    logic [31:0] int_flag_reg;
    logic [31:0] status_now;
    logic [31:0] status_prev_reg;
    logic        lock_reg;
    logic        osc_run;
    logic        wr_ext;
    logic        wr_ulp;

    assign wr_ext = reg_wr && (reg_addr == LFOC_ADDR_EXT_CTRL);
    assign wr_ulp = reg_wr && (reg_addr == LFOC_ADDR_ULP_CTRL);

    // Lock is set by software, cleared only by power-on reset
    always_ff @(posedge clk) begin
        if (por_rst) begin
            lock_reg <= 1'b0;
        end else if (wr_ext && reg_wdata[LFOC_BIT_LOCK]) begin
            lock_reg <= 1'b1;
        end
    end

    // External oscillator control; system reset does not undo the lock
    always_ff @(posedge clk) begin
        if (por_rst || (sys_rst && !lock_reg)) begin
            ext_ctrl_reg <= LFOC_EXT_CTRL_RST;
        end else if (wr_ext && !lock_reg) begin
            ext_ctrl_reg <= reg_wdata & LFOC_EXT_CTRL_WMASK;
        end
    end

    // Low-power oscillator control and calibration
    always_ff @(posedge clk) begin
        if (sys_rst || por_rst) begin
            ulp_ctrl_reg <= LFOC_ULP_CTRL_RST;
        end else if (wr_ulp) begin
            ulp_ctrl_reg <= reg_wdata & LFOC_ULP_CTRL_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || por_rst) begin
            int_en_reg <= 32'h00000000;
        end else if (reg_wr && (reg_addr == LFOC_ADDR_INT_EN)) begin
            int_en_reg <= reg_wdata & LFOC_STATUS_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Run decision in sleep modes
    logic en_bit;
    logic xtal_bit;
    assign en_bit   = ext_ctrl_reg[LFOC_BIT_ENABLE];
    assign xtal_bit = ext_ctrl_reg[LFOC_BIT_XTAL];

    always_comb begin
        if (!en_bit) begin
            osc_run = 1'b0;
        end else if (ext_ctrl_reg[LFOC_BIT_RUN_ON_REQUEST]) begin
            osc_run = clk_request && (!standby_mode || ext_ctrl_reg[LFOC_BIT_RUN_IN_STANDBY]);
        end else begin
            osc_run = !standby_mode || ext_ctrl_reg[LFOC_BIT_RUN_IN_STANDBY];
        end
    end

    logic osc_run_reg;
    always_ff @(posedge clk) begin
        if (sys_rst || por_rst) begin
            osc_run_reg <= 1'b0;
        end else begin
            osc_run_reg <= osc_run;
        end
    end

    // Pin ownership
    always_ff @(posedge clk) begin
        if (sys_rst || por_rst) begin
            xtal_in_pin_override  <= 1'b0;
            xtal_out_pin_override <= 1'b0;
        end else begin
            xtal_in_pin_override  <= en_bit;
            xtal_out_pin_override <= en_bit && xtal_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into the link domain
    logic run_s1_lreg;
    logic run_s2_lreg;
    logic x32_s1_lreg;
    logic x32_s2_lreg;
    logic x1k_s1_lreg;
    logic x1k_s2_lreg;
    logic xt_s1_lreg;
    logic xt_s2_lreg;
    logic rst_s1_lreg;
    logic rst_s2_lreg;

    // Dropping the run request clears the link-side run, startup and gate registers at once; a stopped link clock
    // must not leave a stale run or ready state behind
    always_ff @(posedge xtal_in_clk or negedge osc_run_reg) begin
        if (!osc_run_reg) begin
            run_s1_lreg <= 1'b0;
            run_s2_lreg <= 1'b0;
        end else begin
            run_s1_lreg <= 1'b1;
            run_s2_lreg <= run_s1_lreg;
        end
    end

    always_ff @(posedge xtal_in_clk) begin
        x32_s1_lreg <= ext_ctrl_reg[LFOC_BIT_OUT_32K_ENABLE];
        x32_s2_lreg <= x32_s1_lreg;
        x1k_s1_lreg <= ext_ctrl_reg[LFOC_BIT_OUT_1K_ENABLE];
        x1k_s2_lreg <= x1k_s1_lreg;
        xt_s1_lreg  <= xtal_out_pin_override;
        xt_s2_lreg  <= xt_s1_lreg;
        rst_s1_lreg <= sys_rst || por_rst;
        rst_s2_lreg <= rst_s1_lreg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link-domain logic: startup count, divider, gated outputs
    logic [LFOC_STARTUP_W-1:0] start_cnt_lreg;
    logic                      ready_lreg;
    logic [LFOC_DIV_W-1:0]     div_cnt_lreg;
    logic                      tick_1k_lreg;
    logic                      gate_32k_lreg;
    logic                      gate_1k_lreg;
    logic                      drive_lreg;

    always_ff @(posedge xtal_in_clk or negedge osc_run_reg) begin
        if (!osc_run_reg) begin
            start_cnt_lreg <= '0;
            ready_lreg     <= 1'b0;
        end else if (rst_s2_lreg || !run_s2_lreg) begin
            start_cnt_lreg <= '0;
            ready_lreg     <= 1'b0;
        end else if (!ready_lreg) begin
            start_cnt_lreg <= start_cnt_lreg + 1'b1;
            ready_lreg     <= (start_cnt_lreg == LFOC_STARTUP_W'(LFOC_STARTUP_EDGES - 1));
        end
    end

    always_ff @(posedge xtal_in_clk) begin
        if (rst_s2_lreg || !ready_lreg) begin
            div_cnt_lreg <= '0;
            tick_1k_lreg <= 1'b0;
        end else begin
            div_cnt_lreg <= div_cnt_lreg + 1'b1;
            if (div_cnt_lreg == LFOC_DIV_W'(LFOC_DIV_1K_HALF - 1)) begin
                tick_1k_lreg <= 1'b1;
            end else if (div_cnt_lreg == LFOC_DIV_W'(LFOC_DIV_1K - 1)) begin
                tick_1k_lreg <= 1'b0;
            end
        end
    end

    // Clock gates update while the source clock is low
    always_ff @(negedge xtal_in_clk or negedge osc_run_reg) begin
        if (!osc_run_reg) begin
            gate_32k_lreg <= 1'b0;
            gate_1k_lreg  <= 1'b0;
            drive_lreg    <= 1'b0;
        end else begin
            gate_32k_lreg <= ready_lreg && x32_s2_lreg;
            gate_1k_lreg  <= ready_lreg && x1k_s2_lreg;
            drive_lreg    <= run_s2_lreg && xt_s2_lreg;
        end
    end

    assign clk_32k_out        = xtal_in_clk && gate_32k_lreg;
    assign clk_1k_rtc_out     = tick_1k_lreg && gate_1k_lreg;
    assign xtal_out_pin_drive = !xtal_in_clk && drive_lreg;

    ////////////////////////////////////////////////////////////////////////////
    // Ready back into the system domain
    logic rdy_s1_reg;
    logic rdy_s2_reg;
    always_ff @(posedge clk) begin
        if (sys_rst || por_rst || !osc_run_reg) begin
            rdy_s1_reg <= 1'b0;
            rdy_s2_reg <= 1'b0;
        end else begin
            rdy_s1_reg <= ready_lreg;
            rdy_s2_reg <= rdy_s1_reg;
        end
    end

    always_comb begin
        status_now = 32'h00000000;
        status_now[LFOC_ST_EXT_READY] = rdy_s2_reg && osc_run_reg;
        status_now[LFOC_ST_RUNNING]   = osc_run_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || por_rst) begin
            status_prev_reg <= 32'h00000000;
        end else begin
            status_prev_reg <= status_now;
        end
    end

    // Rising status sets a sticky flag; set wins over write-one clear
    always_ff @(posedge clk) begin
        if (sys_rst || por_rst) begin
            int_flag_reg <= 32'h00000000;
        end else begin
            int_flag_reg <= ((reg_wr && (reg_addr == LFOC_ADDR_INT_FLAG)) ?
                             (int_flag_reg & ~reg_wdata) : int_flag_reg)
                            | (status_now & ~status_prev_reg);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || por_rst) begin
            irq_out  <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            irq_out  <= |(int_flag_reg & int_en_reg);
            wake_out <= standby_mode && |(int_flag_reg & int_en_reg);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || por_rst) begin
            ulp_osc_enable <= 1'b0;
            ulp_osc_cal    <= '0;
        end else begin
            ulp_osc_enable <= ulp_ctrl_reg[LFOC_BIT_ENABLE];
            ulp_osc_cal    <= ulp_ctrl_reg[LFOC_ULP_CAL_LSB +: LFOC_ULP_CAL_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge clk) begin
        if (sys_rst || por_rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                LFOC_ADDR_EXT_CTRL: begin
                    reg_rdata <= ext_ctrl_reg | ({31'h0, lock_reg} << LFOC_BIT_LOCK);
                end
                LFOC_ADDR_ULP_CTRL: reg_rdata <= ulp_ctrl_reg;
                LFOC_ADDR_STATUS:   reg_rdata <= status_now;
                LFOC_ADDR_INT_EN:   reg_rdata <= int_en_reg;
                LFOC_ADDR_INT_FLAG: reg_rdata <= int_flag_reg;
                default:            reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic pend_any;
    assign pend_any = |(int_flag_reg & int_en_reg);

    sequence s_locked;
        lock_reg && wr_ext;
    endsequence

    property p_lock_hold;
        @(posedge clk) disable iff (por_rst)
        s_locked |=> $stable(ext_ctrl_reg);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked config changed");

    property p_lock_sticky;
        @(posedge clk) disable iff (por_rst)
        lock_reg |=> lock_reg;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");

    property p_off_stopped;
        @(posedge clk) disable iff (sys_rst || por_rst)
        !en_bit |=> !osc_run_reg;
    endproperty
    a_off_stopped: assert property (p_off_stopped) else $error("runs while disabled");

    property p_enable_write;
        @(posedge clk) disable iff (sys_rst || por_rst)
        (wr_ext && !lock_reg) |=> en_bit == $past(reg_wdata[LFOC_BIT_ENABLE]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not stored");

    property p_xtal_pins;
        @(posedge clk) disable iff (sys_rst || por_rst)
        (!sys_rst && !por_rst && en_bit) |=>
            xtal_in_pin_override && (xtal_out_pin_override == $past(xtal_bit));
    endproperty
    a_xtal_pins: assert property (p_xtal_pins) else $error("output pin ownership wrong");

    property p_ext_pins;
        @(posedge clk) disable iff (sys_rst || por_rst)
        (!sys_rst && !por_rst && en_bit && !xtal_bit) |=>
            xtal_in_pin_override && !xtal_out_pin_override;
    endproperty
    a_ext_pins: assert property (p_ext_pins) else $error("ext mode pin ownership");

    property p_standby_stop;
        @(posedge clk) disable iff (sys_rst || por_rst)
        (standby_mode && !ext_ctrl_reg[LFOC_BIT_RUN_IN_STANDBY]) |=> !osc_run_reg;
    endproperty
    a_standby_stop: assert property (p_standby_stop) else $error("runs in standby");

    property p_wake_gated;
        @(posedge clk) disable iff (sys_rst || por_rst)
        wake_out |-> $past(pend_any) && $past(standby_mode);
    endproperty
    a_wake_gated: assert property (p_wake_gated) else $error("wake without enable");

    property p_irq_follow;
        @(posedge clk) disable iff (sys_rst || por_rst)
        (!sys_rst && !por_rst) |=> irq_out == $past(pend_any);
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("irq not following flags");

    property p_por_unlock;
        @(posedge clk)
        por_rst |=> !lock_reg;
    endproperty
    a_por_unlock: assert property (p_por_unlock) else $error("lock kept past power-on reset");

    property p_flag_set;
        @(posedge clk) disable iff (sys_rst || por_rst)
        $rose(status_now[LFOC_ST_RUNNING]) |=> int_flag_reg[LFOC_ST_RUNNING];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag lost");

endmodule : lfoc_top

/* include/lfoc_pkg.sv */
package lfoc_pkg;
    // Register byte addresses
    localparam logic [7:0] LFOC_ADDR_EXT_CTRL = 8'h00;
    localparam logic [7:0] LFOC_ADDR_ULP_CTRL = 8'h04;
    localparam logic [7:0] LFOC_ADDR_STATUS   = 8'h08;
    localparam logic [7:0] LFOC_ADDR_INT_EN   = 8'h0C;
    localparam logic [7:0] LFOC_ADDR_INT_FLAG = 8'h10;
    // External oscillator control fields
    localparam int LFOC_BIT_ENABLE   = 1;
    localparam int LFOC_BIT_XTAL     = 2;
    localparam int LFOC_BIT_OUT_32K_ENABLE    = 3;
    localparam int LFOC_BIT_OUT_1K_ENABLE     = 4;
    localparam int LFOC_BIT_RUN_IN_STANDBY = 6;
    localparam int LFOC_BIT_RUN_ON_REQUEST = 7;
    localparam int LFOC_BIT_LOCK     = 12;
    localparam logic [31:0] LFOC_EXT_CTRL_WMASK = 32'h000010DE;
    localparam logic [31:0] LFOC_EXT_CTRL_RST   = 32'h00000080;
    // Ultra-low-power oscillator control fields
    localparam int LFOC_ULP_CAL_LSB  = 8;
    localparam int LFOC_ULP_CAL_W    = 5;
    localparam logic [31:0] LFOC_ULP_CTRL_WMASK = 32'h00001F02;
    localparam logic [31:0] LFOC_ULP_CTRL_RST   = 32'h00001002;
    // Status bits
    localparam int LFOC_ST_EXT_READY = 0;
    localparam int LFOC_ST_RUNNING   = 1;
    localparam logic [31:0] LFOC_STATUS_MASK = 32'h00000003;
    // Link-side clock divide: 32768 / 1024
    localparam int LFOC_DIV_1K       = 32;
    localparam int LFOC_DIV_1K_HALF  = LFOC_DIV_1K / 2;
    localparam int LFOC_DIV_W        = 5;
    // Startup count of link clock edges before ready
    localparam int LFOC_STARTUP_EDGES = 16;
    localparam int LFOC_STARTUP_W     = 5;
endpackage : lfoc_pkg

/* testbench/lfoc_xtal_model.sv */
`timescale 1ns/10ps
module lfoc_xtal_model (
    // Drive from the block
    input  wire logic run,
    // Clock toward the input pin
    output logic      xtal_clk
);
    // Oscillates only while driven, still low otherwise
    initial begin
        xtal_clk = 1'b0;
        #7;
        forever begin
            if (run) begin
                #32 xtal_clk = ~xtal_clk;
            end else begin
                xtal_clk = 1'b0;
                #1;
            end
        end
    end
endmodule // lfoc_xtal_model

/* testbench/lfoc_top_bench.sv */
`timescale 1ns/10ps
module lfoc_top_bench;
    import lfoc_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        por_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        standby_mode = 1'b0;
    logic        clk_request = 1'b0;
    logic        xtal_in_clk;
    logic        in_ovr, out_ovr, out_drv, c32, c1k, ulp_en, irq, wake;
    logic [LFOC_ULP_CAL_W-1:0] ulp_cal;
    logic [31:0] d;
    int          errors = 0;
    int          n_tests = 0;
    int          cnt32 = 0;
    int          cnt1 = 0;
    int          cntd = 0;
    always #12.5 clk = ~clk;
    always @(posedge c32) cnt32++;
    always @(posedge c1k) cnt1++;
    always @(posedge out_drv) cntd++;
    lfoc_top lfoc_top_inst (
        .clk(clk), .sys_rst(sys_rst), .por_rst(por_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .standby_mode(standby_mode), .clk_request(clk_request),
        .xtal_in_clk(xtal_in_clk), .xtal_in_pin_override(in_ovr),
        .xtal_out_pin_override(out_ovr), .xtal_out_pin_drive(out_drv),
        .clk_32k_out(c32), .clk_1k_rtc_out(c1k), .ulp_osc_enable(ulp_en),
        .ulp_osc_cal(ulp_cal), .irq_out(irq), .wake_out(wake)
    );
    lfoc_xtal_model lfoc_xtal_model_inst (
        .run(in_ovr | sys_rst | por_rst), .xtal_clk(xtal_in_clk)
    );
    ////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        for (int i = 0; i < 200; i++) begin
            rd(a);
            if ((d & m) === e) break;
        end
        chk(d & m, e);
        if ((d & m) !== e) end_sim;
    endtask
    task automatic rst_pulse(input logic por);
        @(posedge clk);
        sys_rst <= 1'b1;
        por_rst <= por;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
    endtask
    task automatic pins(input logic [31:0] v, input logic [1:0] e);
        wr(LFOC_ADDR_EXT_CTRL, v);
        repeat (2) @(posedge clk);
        #1;
        chk({30'h0, in_ovr, out_ovr}, {30'h0, e});
    endtask
    task automatic gate(input logic [31:0] v, input logic [2:0] e);
        wr(LFOC_ADDR_EXT_CTRL, v);
        repeat (8) @(posedge clk);
        cnt32 = 0;
        cnt1 = 0;
        cntd = 0;
        repeat (200) @(posedge clk);
        chk({29'h0, cnt32 != 0, cnt1 != 0, cntd != 0}, {29'h0, e});
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(LFOC_ADDR_EXT_CTRL);
        chk(d, LFOC_EXT_CTRL_RST);
        rd(LFOC_ADDR_STATUS);
        chk(d, 32'h0);
        rd(8'h20);
        chk(d, 32'h0);
        chk({30'h0, in_ovr, out_ovr}, 32'h0);
    endtask
    task automatic t_ulp;
        rd(LFOC_ADDR_ULP_CTRL);
        chk(d, LFOC_ULP_CTRL_RST);
        wr(LFOC_ADDR_ULP_CTRL, 32'h00001F02);
        rd(LFOC_ADDR_ULP_CTRL);
        chk(d, 32'h00001F02);
        chk({26'h0, ulp_en, ulp_cal}, 32'h3F);
        wr(LFOC_ADDR_ULP_CTRL, 32'hFFFFE0FD);
        rd(LFOC_ADDR_ULP_CTRL);
        chk(d, 32'h0);
        chk({26'h0, ulp_en, ulp_cal}, 32'h0);
    endtask
    task automatic t_modes;
        pins(32'h02, 2'b10);
        pins(32'h06, 2'b11);
        pins(32'h04, 2'b00);
    endtask
    task automatic t_clocks;
        wr(LFOC_ADDR_EXT_CTRL, 32'h02);
        poll(LFOC_ADDR_STATUS, 32'h1, 32'h1);
        gate(32'h02, 3'b000);
        gate(32'h0A, 3'b100);
        gate(32'h12, 3'b010);
        gate(32'h06, 3'b001);
    endtask
    task automatic t_irq;
        wr(LFOC_ADDR_EXT_CTRL, 32'h00);
        poll(LFOC_ADDR_STATUS, 32'h3, 32'h0);
        wr(LFOC_ADDR_INT_FLAG, 32'h3);
        poll(LFOC_ADDR_INT_FLAG, 32'h3, 32'h0);
        wr(LFOC_ADDR_INT_EN, 32'h1);
        #1;
        chk({31'h0, irq}, 32'h0);
        wr(LFOC_ADDR_EXT_CTRL, 32'h02);
        poll(LFOC_ADDR_INT_FLAG, 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        standby_mode <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, wake}, 32'h1);
        wr(LFOC_ADDR_INT_EN, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        chk({30'h0, wake, irq}, 32'h0);
        @(posedge clk);
        standby_mode <= 1'b0;
        wr(LFOC_ADDR_INT_FLAG, 32'h3);
    endtask
    task automatic t_standby;
        wr(LFOC_ADDR_EXT_CTRL, 32'h42);
        @(posedge clk);
        standby_mode <= 1'b1;
        poll(LFOC_ADDR_STATUS, 32'h2, 32'h2);
        wr(LFOC_ADDR_EXT_CTRL, 32'h02);
        poll(LFOC_ADDR_STATUS, 32'h2, 32'h0);
        wr(LFOC_ADDR_EXT_CTRL, 32'h82);
        poll(LFOC_ADDR_STATUS, 32'h2, 32'h0);
        @(posedge clk);
        clk_request <= 1'b1;
        poll(LFOC_ADDR_STATUS, 32'h2, 32'h0);
        wr(LFOC_ADDR_EXT_CTRL, 32'hC2);
        poll(LFOC_ADDR_STATUS, 32'h2, 32'h2);
        @(posedge clk);
        clk_request <= 1'b0;
        poll(LFOC_ADDR_STATUS, 32'h2, 32'h0);
        wr(LFOC_ADDR_EXT_CTRL, 32'hC8);
        poll(LFOC_ADDR_STATUS, 32'h2, 32'h0);
        gate(32'hC8, 3'b000);
        standby_mode <= 1'b0;
        clk_request <= 1'b0;
    endtask
    task automatic t_lock;
        wr(LFOC_ADDR_EXT_CTRL, 32'h1006);
        rd(LFOC_ADDR_EXT_CTRL);
        chk(d, 32'h1006);
        pins(32'h0, 2'b11);
        rd(LFOC_ADDR_EXT_CTRL);
        chk(d, 32'h1006);
        rst_pulse(1'b0);
        rd(LFOC_ADDR_EXT_CTRL);
        chk(d, 32'h1006);
        rst_pulse(1'b1);
        rd(LFOC_ADDR_EXT_CTRL);
        chk(d, LFOC_EXT_CTRL_RST);
        pins(32'h02, 2'b10);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        errors++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        t_reset;
        t_ulp;
        t_modes;
        t_clocks;
        t_irq;
        t_standby;
        t_lock;
        end_sim;
    end
endmodule // lfoc_top_bench
